// ### include/sampler_defs.svh
// Shared constants for the interlaced dual sampler and its merger
`ifndef SAMPLER_DEFS_SVH
`define SAMPLER_DEFS_SVH

// Timing
`define CLK_PERIOD_NS 10
`define DC_CYCLE_NS 100000
`define OVERSAMPLE 10
`define SHIFT_NS 5000

// Register map
`define FW_VERSION_ADDR 16'h0e00
`define REG_READ_ZERO 16'h0000

// Data handling
`define SCALE_UV_PER_LSB 305
`define FRAME_LEN 20
`define FIFO_DEPTH 32
`define LINK_WORD_W 28

`endif

// ### include/merge_pkg.sv
// Types shared by the sampler unit, the link and the merger
package merge_pkg;

  typedef logic signed [15:0] sample_t;

  // Word carried over the link: bus cycle tag, sample index, first channel
  typedef struct packed {
    logic [7:0] cyc;
    logic [3:0] idx;
    sample_t smp;
  } link_word_t;

  typedef enum logic [1:0] {
    DEV_WAIT = 2'b01,
    DEV_BURST = 2'b10
  } dev_state_t;

  typedef enum logic [1:0] {
    MRG_COLLECT = 2'b01,
    MRG_EMIT = 2'b10
  } mrg_state_t;

endpackage : merge_pkg

// ### include/sampler_link_if.sv
// Link between one sampler unit and the merging controller
`timescale 1ns/1ps
interface sampler_link_if;
  import merge_pkg::*;
  logic [15:0] shift_clks;
  logic op_state;
  logic reg_rd;
  logic [15:0] reg_addr;
  logic [15:0] reg_rdata;
  logic reg_ack;
  logic smp_valid;
  logic smp_ready;
  link_word_t smp_word;
  sample_t smp_ch1;

  modport dev (
    input shift_clks, op_state, reg_rd, reg_addr, smp_ready,
    output reg_rdata, reg_ack, smp_valid, smp_word, smp_ch1
  );
  modport mrg (
    output shift_clks, op_state, reg_rd, reg_addr, smp_ready,
    input reg_rdata, reg_ack, smp_valid, smp_word, smp_ch1
  );
endinterface : sampler_link_if

// ### src/sampler_unit.sv
// Oversampling sampler unit on its local cycle time base, plus the link sample buffer
`timescale 1ns/1ps
`include "sampler_defs.svh"
module sampler_unit #(
  parameter int CYCLE_CLKS = `DC_CYCLE_NS / `CLK_PERIOD_NS,
  parameter logic [15:0] FW_VERSION = 16'h0001 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  sampler_link_if.dev link,
  input wire merge_pkg::sample_t adc_ch0,
  input wire merge_pkg::sample_t adc_ch1,
  output logic sample_strobe,
  output logic overrun
);
  import merge_pkg::*;

  localparam int SMP_CLKS = CYCLE_CLKS / `OVERSAMPLE;

  typedef struct packed {
    dev_state_t st;
    logic [15:0] tcnt;
    logic [7:0] cyc;
    logic [15:0] scnt;
    logic [3:0] bidx;
    logic [7:0] bcyc;
    logic vld;
    link_word_t w0;
    sample_t c1;
    logic strobe;
    logic ovr;
    logic ack;
    logic [15:0] rdata;
  } dev_reg_t;

  dev_reg_t q;
  dev_reg_t d;
  logic cap;
  logic [3:0] cap_idx;
  logic [7:0] cap_cyc;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    cap = 1'b0;
    cap_idx = q.bidx + 4'h1;
    cap_cyc = q.bcyc;
    d.strobe = 1'b0;
    d.ack = 1'b0;
    // Link hands the pending sample over
    if (q.vld && link.smp_ready) begin
      d.vld = 1'b0;
    end
    // Local cycle time base, free running
    if (q.tcnt == 16'(CYCLE_CLKS - 1)) begin
      d.tcnt = '0;
      d.cyc = q.cyc + 8'h01;
    end else begin
      d.tcnt = q.tcnt + 16'h0001;
    end
    // Burst of equally spaced samples per cycle
    case (q.st)
      DEV_WAIT: begin
        if (q.tcnt == link.shift_clks) begin
          d.st = DEV_BURST;
          d.scnt = '0;
          d.bidx = '0;
          d.bcyc = q.cyc;
          cap = 1'b1;
          cap_idx = '0;
          cap_cyc = q.cyc;
        end
      end
      DEV_BURST: begin
        if (q.scnt == 16'(SMP_CLKS - 1)) begin
          d.scnt = '0;
          d.bidx = q.bidx + 4'h1;
          cap = 1'b1;
          if (q.bidx == 4'(`OVERSAMPLE - 2)) begin
            d.st = DEV_WAIT;
          end
        end else begin
          d.scnt = q.scnt + 16'h0001;
        end
      end
      default: begin
        d.st = DEV_WAIT;
      end
    endcase
    // Both channels caught on the same edge
    if (cap) begin
      if (d.vld) begin
        d.ovr = 1'b1;
      end
      d.vld = 1'b1;
      d.w0.cyc = cap_cyc;
      d.w0.idx = cap_idx;
      d.w0.smp = adc_ch0;
      d.c1 = adc_ch1;
      d.strobe = 1'b1;
    end
    // Register read, answered one cycle later
    if (link.reg_rd) begin
      d.ack = 1'b1;
      if (link.op_state && link.reg_addr == `FW_VERSION_ADDR) begin
        d.rdata = FW_VERSION;
      end else begin
        d.rdata = `REG_READ_ZERO;
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{st: DEV_WAIT, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign link.smp_valid = q.vld;
  assign link.smp_word = q.w0;
  assign link.smp_ch1 = q.c1;
  assign link.reg_ack = q.ack;
  assign link.reg_rdata = q.rdata;
  assign sample_strobe = q.strobe;
  assign overrun = q.ovr;

endmodule : sampler_unit

// ------------------------------------------------------------------
// Sample buffer
// ------------------------------------------------------------------
module sample_fifo #(
  parameter int W = `LINK_WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_reg_t;

  fifo_reg_t q;
  fifo_reg_t d;
  logic full;
  logic empty;

  // Pointer compare, extra bit tells full from empty
  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rp[AW-1:0]];

  // Push and pop
  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : sample_fifo

// ### src/stream_merger.sv
// Controller end: buffers two sampler streams and interlaces them per cycle
// Contract
// - Unit starts bursts from local cycle time
// - Ten equally spaced samples per bus cycle
// - Both unit channels sample the same instant
// - Second unit shifted half a sample later
// - Entry 2n first unit, 2n+1 second
// - Samples are signed 16-bit integers
// - Volts scale is 0.000305 per count
// - Bit is one when sample above zero
// - Firmware version readable at 0e00 when operational
`timescale 1ns/1ps
`include "sampler_defs.svh"

// ------------------------------------------------------------------
// Merger
// ------------------------------------------------------------------
module stream_merger #(
  parameter int CYCLE_CLKS = `DC_CYCLE_NS / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic sys_rst,
  sampler_link_if.mrg unit_a,
  sampler_link_if.mrg unit_b,
  input wire logic [15:0] shift_base,
  input wire logic op_enable,
  input wire logic fw_rd,
  input wire logic fw_unit,
  input wire logic [15:0] fw_addr,
  output logic fw_ack,
  output logic [15:0] fw_rdata,
  output logic out_valid,
  input wire logic out_ready,
  output merge_pkg::sample_t out_sample,
  output logic [4:0] out_index,
  output logic signed [31:0] out_uv,
  output logic out_bit,
  output logic out_last,
  output logic sync_err
);
  import merge_pkg::*;

  // Half a sample interval, so the shift tracks a shortened bus cycle
  localparam int SHIFT_CLKS = CYCLE_CLKS / `OVERSAMPLE / 2;

  typedef struct packed {
    mrg_state_t st;
    logic started;
    logic [7:0] ftag;
    logic [3:0] na;
    logic [3:0] nb;
    logic [`FRAME_LEN-1:0][15:0] arr;
    logic [4:0] oidx;
    sample_t osmp;
    logic signed [31:0] ouv;
    logic obit;
    logic err;
    logic rda;
    logic rdb;
    logic [15:0] raddr;
    logic fack;
    logic [15:0] frd;
    logic [15:0] sha;
    logic [15:0] shb;
  } mrg_reg_t;

  mrg_reg_t q;
  mrg_reg_t d;
  logic av;
  logic bv;
  logic pop_a;
  logic pop_b;
  logic abort;
  link_word_t ha;
  link_word_t hb;
  logic [`LINK_WORD_W-1:0] ha_raw;
  logic [`LINK_WORD_W-1:0] hb_raw;
  logic [16:0] shb_sum;
  sample_t nxt;

  // ------------------------------------------------------------------
  // Input buffers, back-pressure reaches each unit
  // ------------------------------------------------------------------
  sample_fifo #(.W(`LINK_WORD_W), .DEPTH(`FIFO_DEPTH)) fifo_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(unit_a.smp_valid),
    .in_ready(unit_a.smp_ready),
    .in_data(unit_a.smp_word),
    .out_valid(av),
    .out_ready(pop_a),
    .out_data(ha_raw)
  );

  sample_fifo #(.W(`LINK_WORD_W), .DEPTH(`FIFO_DEPTH)) fifo_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(unit_b.smp_valid),
    .in_ready(unit_b.smp_ready),
    .in_data(unit_b.smp_word),
    .out_valid(bv),
    .out_ready(pop_b),
    .out_data(hb_raw)
  );

  assign ha = link_word_t'(ha_raw);
  assign hb = link_word_t'(hb_raw);

  // Second unit half a sample interval later, wrapped into the cycle
  assign shb_sum = {1'b0, shift_base} + 17'(SHIFT_CLKS);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    pop_a = 1'b0;
    pop_b = 1'b0;
    abort = 1'b0;
    nxt = q.arr[0];
    d.err = 1'b0;
    d.fack = 1'b0;
    d.rda = 1'b0;
    d.rdb = 1'b0;
    // Shift configuration toward the units
    d.sha = shift_base;
    if (shb_sum >= 17'(CYCLE_CLKS)) begin
      d.shb = 16'(shb_sum - 17'(CYCLE_CLKS));
    end else begin
      d.shb = shb_sum[15:0];
    end
    // Firmware version read toward one unit
    if (fw_rd) begin
      d.rda = !fw_unit;
      d.rdb = fw_unit;
      d.raddr = fw_addr;
    end
    if (unit_a.reg_ack || unit_b.reg_ack) begin
      d.fack = 1'b1;
      d.frd = unit_a.reg_ack ? unit_a.reg_rdata : unit_b.reg_rdata;
    end
    case (q.st)
      MRG_COLLECT: begin
        if (!q.started) begin
          // Align both heads on the same bus cycle
          if (av && bv) begin
            if (ha.cyc == hb.cyc) begin
              d.started = 1'b1;
              d.ftag = ha.cyc;
            end else begin
              d.err = 1'b1;
              if ($signed(8'(ha.cyc - hb.cyc)) < 0) begin
                pop_a = 1'b1;
              end else begin
                pop_b = 1'b1;
              end
            end
          end
        end else begin
          // First unit to even entries
          if (av && q.na != 4'(`OVERSAMPLE)) begin
            if (ha.cyc == q.ftag) begin
              pop_a = 1'b1;
              d.arr[5'({ha.idx, 1'b0})] = ha.smp;
              d.na = q.na + 4'h1;
            end else begin
              abort = 1'b1;
            end
          end
          // Second unit to odd entries
          if (bv && q.nb != 4'(`OVERSAMPLE)) begin
            if (hb.cyc == q.ftag) begin
              pop_b = 1'b1;
              d.arr[5'({hb.idx, 1'b1})] = hb.smp;
              d.nb = q.nb + 4'h1;
            end else begin
              abort = 1'b1;
            end
          end
          // Both arrays complete before any output
          if (q.na == 4'(`OVERSAMPLE) && q.nb == 4'(`OVERSAMPLE)) begin
            d.st = MRG_EMIT;
            d.oidx = '0;
            nxt = q.arr[0];
          end
          if (abort) begin
            d.started = 1'b0;
            d.na = '0;
            d.nb = '0;
            d.err = 1'b1;
          end
        end
      end
      MRG_EMIT: begin
        if (out_ready) begin
          if (q.oidx == 5'(`FRAME_LEN - 1)) begin
            d.st = MRG_COLLECT;
            d.started = 1'b0;
            d.na = '0;
            d.nb = '0;
          end else begin
            d.oidx = q.oidx + 5'h01;
            nxt = q.arr[q.oidx + 5'h01];
          end
        end else begin
          nxt = q.osmp;
        end
      end
      default: begin
        d.st = MRG_COLLECT;
      end
    endcase
    // Output word loaded with its derived values
    d.osmp = nxt;
    d.ouv = 32'(int'(nxt) * `SCALE_UV_PER_LSB);
    d.obit = (nxt > 0);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{st: MRG_COLLECT, default: '0};
    end else begin
      q <= d;
    end
  end

  // Link drive
  assign unit_a.shift_clks = q.sha;
  assign unit_b.shift_clks = q.shb;
  assign unit_a.op_state = op_enable;
  assign unit_b.op_state = op_enable;
  assign unit_a.reg_rd = q.rda;
  assign unit_b.reg_rd = q.rdb;
  assign unit_a.reg_addr = q.raddr;
  assign unit_b.reg_addr = q.raddr;

  // User side
  assign out_valid = (q.st == MRG_EMIT);
  assign out_sample = q.osmp;
  assign out_index = q.oidx;
  assign out_uv = q.ouv;
  assign out_bit = q.obit;
  assign out_last = (q.st == MRG_EMIT) && (q.oidx == 5'(`FRAME_LEN - 1));
  assign sync_err = q.err;
  assign fw_ack = q.fack;
  assign fw_rdata = q.frd;

endmodule : stream_merger

// ### dv/sampler_link_monitor.sv
// Concurrent checks on the first sampler link
`timescale 1ns/1ps
`include "sampler_defs.svh"
module sampler_link_monitor #(
  parameter int CYCLE_CLKS = 200,
  parameter logic [15:0] FW_VERSION = 16'h0001 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] shift_clks,
  input wire logic op_state,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire merge_pkg::link_word_t smp_word,
  input wire merge_pkg::sample_t smp_ch1
);
  import merge_pkg::*;
  localparam int GAP = CYCLE_CLKS / 10;
  logic prev_q;
  logic rise;
  logic [3:0] idx_q;
  logic [15:0] gap_q;
  default clocking mc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------------
  // Arrival timing of samples
  // ------------------------------------------------------------------
  assign rise = smp_valid && !prev_q;
  // Cycles since last new sample, index of last new sample
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
      idx_q <= 4'h0;
      gap_q <= 16'h0000;
    end else begin
      prev_q <= smp_valid;
      idx_q <= rise ? smp_word.idx : idx_q;
      gap_q <= rise ? 16'h0001 : gap_q + 16'h0001;
    end
  end
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_shift_in_cycle: assert property (shift_clks < 16'(CYCLE_CLKS))
    else $error("start offset outside bus cycle");
  a_read_ack_next: assert property (reg_rd |=> reg_ack)
    else $error("read request without answer");
  a_ack_needs_read: assert property (reg_ack |-> $past(reg_rd))
    else $error("answer without read request");
  a_fw_version_value: assert property (
    reg_ack && $past(reg_addr) == `FW_VERSION_ADDR && $past(op_state)
    |-> reg_rdata == FW_VERSION)
    else $error("wrong firmware version read");
  a_refused_read_zero: assert property (
    reg_ack && ($past(reg_addr) != `FW_VERSION_ADDR || !$past(op_state))
    |-> reg_rdata == 16'h0000)
    else $error("refused read not zero");
  a_valid_holds: assert property (smp_valid && !smp_ready |=> smp_valid)
    else $error("sample dropped before taken");
  a_index_range: assert property (smp_valid |-> smp_word.idx <= 4'h9)
    else $error("sample index above nine");
  a_sample_gap: assert property (rise && smp_word.idx != 4'h0 |-> gap_q == 16'(GAP))
    else $error("samples not equally spaced");
  a_index_step: assert property (rise && smp_word.idx != 4'h0 |-> smp_word.idx == idx_q + 4'h1)
    else $error("sample index skipped");
  a_channels_paired: assert property (smp_valid |-> smp_ch1 == smp_word.smp)
    else $error("channels not from same instant");
endmodule : sampler_link_monitor

// ### dv/interlaced_dual_sampler_merge_tb_top.sv
// Self-checking bench joining both sampler units to the merger
`timescale 1ns/1ps
`include "sampler_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module interlaced_dual_sampler_merge_tb_top;
  import merge_pkg::*;
  localparam int CYC = 200;
  localparam logic [15:0] FW_A = 16'h00a5; // Arbitrary value
  localparam logic [15:0] FW_B = 16'h005a; // Arbitrary value
  logic clk, sys_rst, op_enable, fw_rd, fw_unit, out_ready, strobe_a, ovr_a;
  logic err_seen = 1'b0;
  logic fw_ack, out_valid, out_bit, out_last, sync_err;
  logic [15:0] shift_base, fw_addr, fw_rdata;
  logic [4:0] out_index;
  logic signed [31:0] out_uv;
  sample_t adc_a, adc_b, out_sample;
  sample_t fs [20];
  logic [4:0] fi [20];
  logic signed [31:0] fu [20];
  logic fb [20];
  logic fl [20];
  int compares = 0, miscompares = 0, ticks = 0, strobes = 0;
  sample_t tab [6] = '{16'sh03e8, 16'shf830, 16'sh0000, 16'sh0001, 16'sh7fff, 16'sh8000};
  sampler_link_if link_a ();
  sampler_link_if link_b ();
  sampler_unit #(.CYCLE_CLKS(CYC), .FW_VERSION(FW_A)) sampler_unit_inst (.clk(clk),
    .sys_rst(sys_rst), .link(link_a), .adc_ch0(adc_a), .adc_ch1(adc_a),
    .sample_strobe(strobe_a), .overrun(ovr_a));
  sampler_unit #(.CYCLE_CLKS(CYC), .FW_VERSION(FW_B)) sampler_unit_b_inst (.clk(clk),
    .sys_rst(sys_rst), .link(link_b), .adc_ch0(adc_b), .adc_ch1(adc_b),
    .sample_strobe(), .overrun());
  stream_merger #(.CYCLE_CLKS(CYC)) stream_merger_inst (.clk(clk), .sys_rst(sys_rst),
    .unit_a(link_a), .unit_b(link_b), .shift_base(shift_base), .op_enable(op_enable),
    .fw_rd(fw_rd), .fw_unit(fw_unit), .fw_addr(fw_addr), .fw_ack(fw_ack),
    .fw_rdata(fw_rdata), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample), .out_index(out_index), .out_uv(out_uv), .out_bit(out_bit),
    .out_last(out_last), .sync_err(sync_err));
  sampler_link_monitor #(.CYCLE_CLKS(CYC), .FW_VERSION(FW_A)) sampler_link_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .shift_clks(link_a.shift_clks),
    .op_state(link_a.op_state), .reg_rd(link_a.reg_rd), .reg_addr(link_a.reg_addr),
    .reg_rdata(link_a.reg_rdata), .reg_ack(link_a.reg_ack), .smp_valid(link_a.smp_valid),
    .smp_ready(link_a.smp_ready), .smp_word(link_a.smp_word), .smp_ch1(link_a.smp_ch1));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard and frame fault watch
  always @(posedge clk) begin
    ticks++;
    if (sync_err === 1'b1) err_seen = 1'b1;
    if (strobe_a === 1'b1) strobes++;
    if (ticks == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One register read through the merger, answer checked
  task automatic fw_read(input logic u, input logic [15:0] a, input logic [15:0] e);
    int k;
    @(posedge clk);
    fw_rd <= 1'b1;
    fw_unit <= u;
    fw_addr <= a;
    @(posedge clk);
    fw_rd <= 1'b0;
    for (k = 1; k < 9; k++) begin
      @(posedge clk);
      #1;
      if (fw_ack === 1'b1) break;
    end
    `CHK("fw_latency", 2, k)
    `CHK("fw_rdata", e, fw_rdata)
  endtask : fw_read

  // Collect one merged frame, optionally compare it
  task automatic take_frame(input sample_t a, input sample_t b, input bit chk);
    int n;
    int k;
    sample_t e;
    n = 0;
    for (k = 0; k < 3000 && n < 20; k++) begin
      @(negedge clk);
      if (out_valid === 1'b1) begin
        if (out_index === 5'h00) n = 0;
        fi[n] = out_index;
        fs[n] = out_sample;
        fu[n] = out_uv;
        fb[n] = out_bit;
        fl[n] = out_last;
        n++;
      end
    end
    `CHK("frame_len", 20, n)
    for (k = 0; k < 20 && chk; k++) begin
      e = k[0] ? b : a;
      `CHK("index", 5'(k), fi[k])
      `CHK("sample", e, fs[k])
      `CHK("microvolts", 32'(int'(e) * `SCALE_UV_PER_LSB), fu[k])
      `CHK("bit", e > 0, fb[k])
      `CHK("last", k == 19, fl[k])
    end
  endtask : take_frame
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int i;
    int j;
    sys_rst = 1'b1;
    op_enable = 1'b1;
    fw_rd = 1'b0;
    fw_unit = 1'b0;
    out_ready = 1'b1;
    shift_base = 16'h000a;
    fw_addr = 16'h0000;
    adc_a = 16'sh0000;
    adc_b = 16'sh0000;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("shift_a", 16'h000a, link_a.shift_clks)
    `CHK("shift_b", 16'(10 + CYC / `OVERSAMPLE / 2), link_b.shift_clks)
    $display("test shift done");
    fw_read(1'b0, `FW_VERSION_ADDR, FW_A);
    fw_read(1'b1, `FW_VERSION_ADDR, FW_B);
    fw_read(1'b0, 16'h0e02, `REG_READ_ZERO);
    @(posedge clk);
    op_enable <= 1'b0;
    fw_read(1'b1, `FW_VERSION_ADDR, `REG_READ_ZERO);
    @(posedge clk);
    op_enable <= 1'b1;
    $display("test registers done");
    for (i = 0; i < 6; i += 2) begin
      @(posedge clk);
      adc_a <= tab[i];
      adc_b <= tab[i + 1];
      for (j = 0; j < 3; j++) take_frame(tab[i], tab[i + 1], j == 2);
    end
    `CHK("sync_err", 1'b0, err_seen)
    `CHK("overrun_idle", 1'b0, ovr_a)
    // Any window of one bus cycle holds exactly ten sample strobes
    @(posedge clk);
    #1;
    i = strobes;
    repeat (CYC) @(posedge clk);
    #1;
    `CHK("strobes", 10, strobes - i)
    $display("test frames done");
    @(posedge clk);
    out_ready <= 1'b0;
    for (i = 0; i < 2000 && link_a.smp_ready !== 1'b0; i++) @(posedge clk);
    #1;
    `CHK("fifo_full", 1'b0, link_a.smp_ready)
    `CHK("held_valid", 1'b1, out_valid)
    // Two more captures with the buffer full must flag the loss
    repeat (CYC / 4) @(posedge clk);
    #1;
    `CHK("overrun", 1'b1, ovr_a)
    $display("test stall done");
    complete_run();
  end
endmodule : interlaced_dual_sampler_merge_tb_top
